// [verilog/usr_pkg.sv]
// Package for the single-channel status and ready timing UART core
//
// Operation
// - Receive interrupt within one tick of stop
// - Transmit starts 8 to 24 ticks after clear
// - Receive ready within one clock of stop
// - Receive ready released within 1 us of read
// - Transmit ready low within 16 ticks of start
// - Baud tick runs at sixteen times bit rate
// - Single-byte mode: data valid one tick later
// - Buffered mode: data valid with status
package usr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int CLK_PERIOD_NS = 50;         // sys_clk at 20 MHz
   localparam int RDY_REL_NS = 1000;          // Longest release of rx ready
   localparam int RDY_REL_CYC = RDY_REL_NS / CLK_PERIOD_NS; // Rounds down
   localparam logic [3:0] OVS_LAST = 4'hF;    // Sixteen ticks per bit
   localparam logic [3:0] RX_MID = 4'h7;      // Middle of the start bit
   localparam logic [4:0] TX_DLY_LAST = 5'h0F; // Sixteen ticks before start
   localparam int TX_DLY_MIN = 8;             // Least start delay in ticks
   localparam int TX_DLY_MAX = 24;            // Longest start delay in ticks
   localparam logic [3:0] DATA_BITS = 4'h8;   // Character length
   localparam logic [3:0] FRAME_BITS = 4'hA;  // Start, eight data, stop
   localparam logic [15:0] DIV_RESET = 16'h0001; // Fallback for divisor 0

   ////////////////////////////////////////////////////////////////////////////
   // Widths and reset values
   localparam int DATA_W = 8;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Status word toward the host
   typedef struct packed {
      logic rx_ready_indicator; // Character waiting in rx_holding_reg
      logic tx_ready_indicator; // Transmit path idle and empty
      logic rx_irq;             // Data available interrupt
      logic tx_irq;             // Holding empty interrupt
      logic overrun;            // Sticky: character lost
      logic frame_err;          // Sticky: stop bit sampled low
   } usr_status_t;

   localparam usr_status_t STATUS_RESET = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage : usr_pkg

// [verilog/usr_baud_gen.sv]
// Baud tick generator at sixteen times the bit rate
`timescale 1ns/100ps
module usr_baud_gen (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [15:0] divisor,
   output logic baud_tick
);
   import usr_pkg::*;

   logic [15:0] cnt_r;   // Clocks since the last tick
   logic [15:0] div_eff; // Divisor with zero mapped to one

   // A zero divisor would stall the line forever, so it counts as one
   assign div_eff = (divisor == 16'h0000) ? DIV_RESET : divisor;

   ////////////////////////////////////////////////////////////////////////////
   // Divider: one tick every div_eff enabled clocks
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r <= 16'h0000;
         baud_tick <= 1'b0;
      end else if (clk_en) begin
         if (cnt_r >= div_eff - 16'h0001) begin
            cnt_r <= 16'h0000;
            baud_tick <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 16'h0001;
            baud_tick <= 1'b0;
         end
      end
   end

endmodule : usr_baud_gen

// [verilog/usr_buf2.sv]
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module usr_buf2 (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [7:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [7:0] out_data
);
   import usr_pkg::*;

   logic [7:0] mem_r [2]; // Entry storage
   logic wr_ptr_r;        // Next entry to fill
   logic rd_ptr_r;        // Oldest entry
   logic [1:0] count_r;   // Entries held
   logic push;
   logic pop;

   assign in_ready = (count_r != 2'h2);
   assign out_valid = (count_r != 2'h0);
   assign out_data = mem_r[rd_ptr_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Entry storage, one process per entry
   for (genvar i = 0; i < 2; i++) begin : g_entry
      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) begin
            mem_r[i] <= BYTE_RESET;
         end else if (clk_en && push && (wr_ptr_r == 1'(i))) begin
            mem_r[i] <= in_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pointers and fill count
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r <= 2'h0;
      end else if (clk_en) begin
         if (push) begin
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         // Push and pop together leave the count alone
         if (push && !pop) begin
            count_r <= count_r + 2'h1;
         end else if (pop && !push) begin
            count_r <= count_r - 2'h1;
         end
      end
   end

endmodule : usr_buf2

// [verilog/usr_uart_core.sv]
// Single-channel UART core with host status and ready timing
`timescale 1ns/100ps
module usr_uart_core (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [15:0] divisor,
   input wire logic fifo_mode,
   input wire logic host_read_strobe,
   input wire logic host_write_strobe,
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata,
   output usr_pkg::usr_status_t status,
   input wire logic rx_line,
   output logic tx_line
);
   import usr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usr_rx_state_t;
   typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT} usr_tx_state_t;

   logic baud_tick;            // Sixteen-times bit rate strobe
   usr_rx_state_t rx_state_r;  // Receiver sequencer
   logic [3:0] rx_cnt_r;       // Ticks inside the current bit
   logic [3:0] rx_bits_r;      // Data bits taken so far
   logic [7:0] rx_shift_r;     // Assembling character, LSB first
   logic [7:0] rx_stage_r;     // Completed character awaiting load
   logic [7:0] rx_hold_r;      // The rx_holding_reg seen by the host
   logic lag_pend_r;           // Single-byte load waits for a tick
   logic stop_take;            // Stop bit sampled this cycle
   logic rd_dly_r;             // Read strobe one clock ago
   logic wr_dly_r;             // Write strobe one clock ago
   logic rd_edge;              // Leading edge of a host read
   logic wr_edge;              // Leading edge of a host write
   usr_status_t status_r;      // Status word gathered from the flag flops
   logic rx_rdy_r;             // Character waiting in the holding register
   logic tx_rdy_r;             // Transmit path idle and empty
   logic rx_irq_r;             // Data available interrupt
   logic tx_irq_r;             // Holding empty interrupt
   logic overrun_r;            // Sticky: character lost
   logic frame_err_r;          // Sticky: stop bit sampled low
   usr_tx_state_t tx_state_r;  // Transmitter sequencer
   logic [4:0] tx_wait_r;      // Ticks spent before the start bit
   logic [3:0] tx_cnt_r;       // Ticks inside the current bit
   logic [3:0] tx_bits_r;      // Frame bits already sent
   logic [9:0] tx_shift_r;     // Frame being sent, LSB first
   logic tx_line_r;            // Serial output flop
   logic tx_go;                // First tick of the start bit
   logic buf_in_ready;
   logic buf_out_valid;
   logic [7:0] buf_out_data;
   logic wr_take;              // Host write accepted by the buffer
   logic tx_busy_nxt;          // Anything waiting or in flight

   assign host_rdata = rx_hold_r;
   assign status = status_r;
   // Each flag has its own flop so that each process drives only its own flags
   assign status_r = '{rx_rdy_r, tx_rdy_r, rx_irq_r, tx_irq_r, overrun_r, frame_err_r};
   assign tx_line = tx_line_r;

   ////////////////////////////////////////////////////////////////////////////
   // Baud tick and transmit buffer
   usr_baud_gen u_baud (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .divisor(divisor),
      .baud_tick(baud_tick)
   );

   // The buffer lets a second write land while a frame is on the line
   usr_buf2 u_txbuf (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .in_valid(wr_edge),
      .in_ready(buf_in_ready),
      .in_data(host_wdata),
      .out_valid(buf_out_valid),
      .out_ready(tx_go),
      .out_data(buf_out_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Host strobe edges; a strobe held for many clocks acts once
   assign rd_edge = host_read_strobe && !rd_dly_r;
   assign wr_edge = host_write_strobe && !wr_dly_r;
   assign wr_take = wr_edge && buf_in_ready;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_dly_r <= 1'b0;
         wr_dly_r <= 1'b0;
      end else if (clk_en) begin
         rd_dly_r <= host_read_strobe;
         wr_dly_r <= host_write_strobe;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receiver sequencer, sampling at the middle of each bit
   assign stop_take = (rx_state_r == RX_STOP) && baud_tick && (rx_cnt_r == OVS_LAST);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_state_r <= RX_IDLE;
         rx_cnt_r <= 4'h0;
         rx_bits_r <= 4'h0;
         rx_shift_r <= BYTE_RESET;
      end else if (clk_en && baud_tick) begin
         case (rx_state_r)
            RX_IDLE: begin
               // Falling edge of the line may be a start bit
               rx_cnt_r <= 4'h0;
               if (!rx_line) begin
                  rx_state_r <= RX_START;
               end
            end
            RX_START: begin
               rx_cnt_r <= rx_cnt_r + 4'h1;
               if (rx_cnt_r == RX_MID) begin
                  // A glitch shorter than half a bit is dropped
                  rx_state_r <= rx_line ? RX_IDLE : RX_DATA;
                  rx_cnt_r <= 4'h0;
                  rx_bits_r <= 4'h0;
               end
            end
            RX_DATA: begin
               rx_cnt_r <= rx_cnt_r + 4'h1;
               if (rx_cnt_r == OVS_LAST) begin
                  rx_shift_r <= {rx_line, rx_shift_r[7:1]};
                  rx_bits_r <= rx_bits_r + 4'h1;
                  if (rx_bits_r == DATA_BITS - 4'h1) begin
                     rx_state_r <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               rx_cnt_r <= rx_cnt_r + 4'h1;
               if (rx_cnt_r == OVS_LAST) begin
                  rx_state_r <= RX_IDLE;
               end
            end
            default: begin
               rx_state_r <= RX_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Holding register load: at once when buffered, one tick late otherwise
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_stage_r <= BYTE_RESET;
         rx_hold_r <= BYTE_RESET;
         lag_pend_r <= 1'b0;
      end else if (clk_en) begin
         if (stop_take) begin
            rx_stage_r <= rx_shift_r;
            if (fifo_mode) begin
               rx_hold_r <= rx_shift_r;
               lag_pend_r <= 1'b0;
            end else begin
               // Status leads the data here; host software must wait a tick
               lag_pend_r <= 1'b1;
            end
         end else if (lag_pend_r && baud_tick) begin
            rx_hold_r <= rx_stage_r;
            lag_pend_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive status: set wins over the host read that clears it
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_rdy_r <= STATUS_RESET.rx_ready_indicator;
         rx_irq_r <= STATUS_RESET.rx_irq;
         overrun_r <= STATUS_RESET.overrun;
         frame_err_r <= STATUS_RESET.frame_err;
      end else if (clk_en) begin
         if (stop_take) begin
            rx_rdy_r <= 1'b1;
            rx_irq_r <= 1'b1;
            // Unread character is overwritten in either mode
            if (rx_rdy_r && !rd_edge) begin
               overrun_r <= 1'b1;
            end
            if (!rx_line) begin
               frame_err_r <= 1'b1;
            end
         end else if (rd_edge) begin
            // Read marks the holding register empty and drops all four receive flags
            rx_rdy_r <= 1'b0;
            rx_irq_r <= 1'b0;
            overrun_r <= 1'b0;
            frame_err_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter sequencer: fixed wait, then a ten-bit frame
   assign tx_go = (tx_state_r == TX_WAIT) && baud_tick && (tx_wait_r == TX_DLY_LAST);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_state_r <= TX_IDLE;
         tx_wait_r <= 5'h00;
         tx_cnt_r <= 4'h0;
         tx_bits_r <= 4'h0;
         tx_shift_r <= 10'h3FF;
      end else if (clk_en) begin
         case (tx_state_r)
            TX_IDLE: begin
               tx_wait_r <= 5'h00;
               if (buf_out_valid) begin
                  tx_state_r <= TX_WAIT;
               end
            end
            TX_WAIT: begin
               // Sixteen ticks sit in the middle of the allowed window
               if (tx_go) begin
                  tx_shift_r <= {1'b1, buf_out_data, 1'b0};
                  tx_cnt_r <= 4'h0;
                  tx_bits_r <= 4'h0;
                  tx_state_r <= TX_SHIFT;
               end else if (baud_tick) begin
                  tx_wait_r <= tx_wait_r + 5'h01;
               end
            end
            TX_SHIFT: begin
               if (baud_tick) begin
                  tx_cnt_r <= tx_cnt_r + 4'h1;
                  if (tx_cnt_r == OVS_LAST) begin
                     tx_shift_r <= {1'b1, tx_shift_r[9:1]};
                     tx_bits_r <= tx_bits_r + 4'h1;
                     if (tx_bits_r == FRAME_BITS - 4'h1) begin
                        tx_state_r <= TX_IDLE;
                     end
                  end
               end
            end
            default: begin
               tx_state_r <= TX_IDLE;
            end
         endcase
      end
   end

   // Serial output is a flop so the line never glitches
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_line_r <= 1'b1;
      end else if (clk_en) begin
         tx_line_r <= (tx_state_r == TX_SHIFT) ? tx_shift_r[0] : 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit status; the ready flag stays low while a frame is out
   assign tx_busy_nxt = wr_take || buf_out_valid || (tx_state_r != TX_IDLE);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_rdy_r <= STATUS_RESET.tx_ready_indicator;
         tx_irq_r <= STATUS_RESET.tx_irq;
      end else if (clk_en) begin
         tx_rdy_r <= !tx_busy_nxt;
         // Last word leaving the buffer raises the empty interrupt; a buffer
         // with room at the start holds nothing but the leaving word
         if (tx_go && buf_in_ready && !wr_take) begin
            tx_irq_r <= 1'b1;
         end else if (wr_take) begin
            tx_irq_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   localparam int RDY_REL_LIM = RDY_REL_CYC;
   logic [15:0] gap_r;    // Clocks since the previous baud tick
   logic gap_ok_r;        // A previous tick has been seen
   logic [15:0] div_chk;

   assign div_chk = (divisor == 16'h0000) ? DIV_RESET : divisor;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gap_r <= 16'h0000;
         gap_ok_r <= 1'b0;
      end else if (clk_en) begin
         gap_r <= baud_tick ? 16'h0001 : gap_r + 16'h0001;
         gap_ok_r <= gap_ok_r || baud_tick;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst || !clk_en);

   chk_rx_irq_set: assert property (stop_take |=> status_r.rx_irq)
      else $error("rx interrupt not raised after stop bit");
   chk_rx_rdy_set: assert property (stop_take |=> status_r.rx_ready_indicator)
      else $error("rx ready not raised within one clock of stop bit");
   chk_rx_rdy_rel: assert property (rd_edge && !stop_take |-> ##[1:RDY_REL_LIM] !status_r.rx_ready_indicator)
      else $error("rx ready not released after host read");
   chk_tx_start_win: assert property (tx_go |-> (tx_wait_r >= 5'(TX_DLY_MIN - 1)) && (tx_wait_r <= 5'(TX_DLY_MAX - 1)))
      else $error("transmit start outside allowed delay window");
   chk_tx_start_bit: assert property (tx_go |-> ##2 !tx_line)
      else $error("start bit not driven after transmit start");
   chk_tx_rdy_low: assert property (tx_go |=> !status_r.tx_ready_indicator [*8])
      else $error("tx ready high while frame in flight");
   chk_baud_rate: assert property (baud_tick && gap_ok_r && $stable(divisor) |-> gap_r == div_chk)
      else $error("baud tick spacing differs from divisor");
   chk_lag_load: assert property (stop_take && !fifo_mode |=> $stable(rx_hold_r) && lag_pend_r)
      else $error("single-byte data loaded without tick lag");
   chk_lag_done: assert property (lag_pend_r && baud_tick && !stop_take |=> rx_hold_r == $past(rx_stage_r))
      else $error("single-byte data not loaded on next tick");
   chk_fifo_load: assert property (stop_take && fifo_mode |=> rx_hold_r == $past(rx_shift_r))
      else $error("buffered data not readable with status");

   cov_rx_char: cover property (stop_take ##1 status_r.rx_irq);
   cov_tx_frame: cover property (tx_go);
   cov_rx_overrun: cover property ($rose(status_r.overrun));
   cov_tx_full: cover property (wr_edge && !buf_in_ready);

endmodule : usr_uart_core

// [testbench/usr_host_model.sv]
// Host processor model that drives the parallel read and write strobes
`timescale 1ns/100ps
module usr_host_model (
   input wire logic sys_clk,
   output logic host_read_strobe,
   output logic host_write_strobe,
   output logic [7:0] host_wdata
);
   ////////////////////////////////////////////////////////////////////////////
   // Strobes idle low, data bus parked on a pattern the core never expects
   initial begin
      host_read_strobe = 1'b0;
      host_write_strobe = 1'b0;
      host_wdata = 8'hA5;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One access: strobe high two clocks, then low two clocks before the next
   task automatic access(input logic is_wr, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      host_wdata = d;
      if (is_wr) begin
         host_write_strobe = 1'b1;
      end else begin
         host_read_strobe = 1'b1;
      end
      repeat (2) @(posedge sys_clk);
      #1;
      host_read_strobe = 1'b0;
      host_write_strobe = 1'b0;
      host_wdata = ~d; // Released bus must not keep showing the byte
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : access
endmodule : usr_host_model

// [testbench/usr_uart_core_tb_top.sv]
// Self-checking testbench for the status and ready timing UART core
`timescale 1ns/100ps
module usr_uart_core_tb_top;
   import usr_pkg::*;
   localparam int DIV = 2;        // Clocks per baud tick, keeps the run short
   localparam int BIT = 16 * DIV; // Clocks per serial bit
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic fifo_mode = 1'b0;
   logic clk_en = 1'b1;           // Core runs unless a test freezes it
   logic rx_line = 1'b1;          // Serial idle level
   logic rd_s;
   logic wr_s;
   logic tx_line;
   logic [7:0] wdata;
   logic [7:0] rdata;
   usr_status_t status;
   int fails = 0;
   int comparisons = 0;
   int cyc = 0;
   logic [31:0] rng = 32'h00000014; // Fixed seed for repeatable runs

   usr_uart_core DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .divisor(16'(DIV)),
      .fifo_mode(fifo_mode), .host_read_strobe(rd_s), .host_write_strobe(wr_s), .host_wdata(wdata),
      .host_rdata(rdata), .status(status), .rx_line(rx_line), .tx_line(tx_line));
   usr_host_model host (.sys_clk(sys_clk), .host_read_strobe(rd_s), .host_write_strobe(wr_s),
      .host_wdata(wdata));

   ////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial begin
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         finish_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [7:0] rnd8();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng[7:0];
   endfunction : rnd8

   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : step

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Send one frame on rx_line; flag timing is measured only if nothing waits
   task automatic rx_byte(input logic [7:0] d, input logic stop_bit, input logic [7:0] prev);
      logic [9:0] fr;
      logic had;
      int n;
      fr = {stop_bit, d, 1'b0};
      had = status.rx_ready_indicator;
      for (int i = 0; i < 10; i++) begin
         rx_line = fr[i];
         if (i < 9) step(BIT);
      end
      n = 0;
      while (!had && status.rx_ready_indicator !== 1'b1 && n < BIT) begin
         step(1);
         n++;
      end
      if (had) step(BIT / 2 + DIV + 2); // Stop bit is taken in the middle of the bit
      if (!had) begin
         check("rx flag time", 8'((n >= BIT / 2 - 2) && (n <= BIT / 2 + DIV + 2)), 8'h01);
         check("rx irq", {7'h00, status.rx_irq}, 8'h01);
         check("rx data at flag", rdata, fifo_mode ? d : prev);
      end
      step(DIV + 1);
      check("rx data", rdata, d);
      check("frame err", {7'h00, status.frame_err}, {7'h00, ~stop_bit});
      check("overrun", {7'h00, status.overrun}, {7'h00, had});
      rx_line = 1'b1;
      step(BIT);
   endtask : rx_byte

   // Read and confirm that every receive flag is released
   task automatic rx_read();
      host.access(1'b0, 8'h00);
      check("rx ready release", {2'h0, status} & 8'h2B, 8'h00);
   endtask : rx_read

   // Find a start bit and check the frame bit by bit
   task automatic tx_check(input logic [7:0] d, input logic timed, input logic last);
      int n;
      n = 0;
      while (tx_line !== 1'b0 && n < 60 * DIV) begin
         step(1);
         n++;
      end
      if (timed) check("tx start delay", 8'((n + 3 >= 8 * DIV) && (n + 3 <= 24 * DIV + 3)), 8'h01);
      step(BIT / 2);
      check("tx start bit", {7'h00, tx_line}, 8'h00);
      check("tx ready low", {7'h00, status.tx_ready_indicator}, 8'h00);
      check("tx irq", {7'h00, status.tx_irq}, {7'h00, last});
      for (int i = 0; i < 8; i++) begin
         step(BIT);
         check("tx data bit", {7'h00, tx_line}, {7'h00, d[i]});
      end
      step(BIT);
      check("tx stop bit", {7'h00, tx_line}, 8'h01);
   endtask : tx_check

   task automatic finish_test();
      $display("Counts: comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [7:0] d;
      logic [7:0] prev;
      logic [7:0] w0;
      logic [7:0] w1;
      step(12);
      sys_rst = 1'b0;
      check("status reset", {2'h0, status}, {2'h0, STATUS_RESET});
      check("rdata reset", rdata, 8'h00);
      check("tx idle", {7'h00, tx_line}, 8'h01);
      prev = 8'h00;
      // Both modes, corner bytes then random ones
      for (int k = 0; k < 6; k++) begin
         fifo_mode = k[0];
         d = (k < 2) ? (k[0] ? 8'h01 : 8'h80) : rnd8();
         rx_byte(d, 1'b1, prev);
         rx_read();
         prev = d;
      end
      $display("Test receive timing done");
      // Stop bit low, then a second character before the first is read
      rx_byte(8'h3C, 1'b0, prev);
      rx_read();
      rx_byte(8'h11, 1'b1, 8'h3C);
      rx_byte(8'h22, 1'b1, 8'h11);
      rx_read();
      $display("Test receive errors done");
      // Single write with start delay measured from the interrupt clear
      d = rnd8();
      host.access(1'b1, d);
      check("tx ready after write", {7'h00, status.tx_ready_indicator}, 8'h00);
      check("tx irq cleared", {7'h00, status.tx_irq}, 8'h00);
      tx_check(d, 1'b1, 1'b1);
      step(BIT / 2 + 2);
      check("tx ready idle", {7'h00, status.tx_ready_indicator}, 8'h01);
      // Three writes back to back: two queue, the third is refused
      w0 = rnd8();
      w1 = rnd8();
      host.access(1'b1, w0);
      host.access(1'b1, w1);
      host.access(1'b1, 8'h00);
      tx_check(w0, 1'b0, 1'b0);
      tx_check(w1, 1'b0, 1'b1);
      step(30 * DIV);
      check("dropped word idle", {7'h00, tx_line}, 8'h01);
      check("tx ready final", {7'h00, status.tx_ready_indicator}, 8'h01);
      $display("Test transmit done");
      // Clock enable low freezes the core, so a write made then is never seen
      clk_en = 1'b0;
      host.access(1'b1, 8'h5A);
      check("frozen tx ready", {7'h00, status.tx_ready_indicator}, 8'h01);
      clk_en = 1'b1;
      step(40 * DIV);
      check("write while frozen", {7'h00, status.tx_ready_indicator}, 8'h01);
      check("line while frozen", {7'h00, tx_line}, 8'h01);
      $display("Test clock enable done");
      finish_test();
   end
endmodule : usr_uart_core_tb_top
